// [rtl/rfmc_pkg.sv]
// Package of constants and carrier types for the regulator fault and mode control block.
package rfmc_pkg;
    localparam int CLK_MHZ = 125;
    localparam int RESTART_MS = 200;
    localparam int RESTART_CYC = RESTART_MS * 1000 * CLK_MHZ;
    localparam int OV_DEGLITCH_US = 10;
    localparam int OV_DEGLITCH_CYC = OV_DEGLITCH_US * CLK_MHZ;
    localparam int SST_SHORT_US = 140;
    localparam int SST_LONG_US = 280;
    localparam int SST_SHORT_CYC = SST_SHORT_US * CLK_MHZ;
    localparam int SST_LONG_CYC = SST_LONG_US * CLK_MHZ;
    localparam int SEQ_STEP_US = 100;
    localparam int SEQ_STEP_CYC = SEQ_STEP_US * CLK_MHZ;
    localparam int NUM_RAILS = 6;
    localparam int VCODE_W = 6;
    localparam logic MASK_RESET = 1'b1;
    localparam logic [VCODE_W-1:0] VCODE_RESET = 6'h18;
    // Rail indices: four bucks, then the two LDOs.
    localparam int RAIL_B1 = 0;
    localparam int RAIL_B4 = 3;
    localparam int RAIL_L1 = 4;
    localparam int RAIL_L2 = 5;

    typedef enum {ST_OFF, ST_SEQ, ST_ACTIVE, ST_FAULT} rfmc_state_e;

    typedef struct packed {
        logic discharge_enable;
        logic softstart_select;
        logic current_limit_scale;
    } rfmc_ldo_cfg_s;

    typedef struct packed {
        logic undervoltage;
        logic overvoltage;
        logic current_limit;
    } rfmc_mask_s;
endpackage

// [rtl/rfmc_softstart.sv]
// Soft-start ramp timer for one LDO.
`timescale 1ns/1ps
`default_nettype none
module rfmc_softstart
    import rfmc_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic enable,
    input wire logic long_sel,
    output logic ramping,
    output logic done
);
    localparam int CW = $clog2(SST_LONG_CYC + 1);
    logic [CW-1:0] cnt_reg;
    logic en_d_reg;
    wire logic start = enable && !en_d_reg;
    wire logic [CW-1:0] limit = long_sel ? CW'(SST_LONG_CYC) : CW'(SST_SHORT_CYC);
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            cnt_reg <= '0;
            en_d_reg <= 1'b0;
        end else begin
            en_d_reg <= enable;
            if (!enable || start) begin
                cnt_reg <= '0;
            end else if (cnt_reg < limit) begin
                cnt_reg <= cnt_reg + 1'b1;
            end
        end
    end
    assign ramping = enable && (cnt_reg < limit);
    assign done = enable && !start && (cnt_reg >= limit);
endmodule
`default_nettype wire

// [rtl/rfmc_top.sv]
// Fault, mode and LDO control logic of the multi-output regulator.
`timescale 1ns/1ps
`default_nettype none
module rfmc_top
    import rfmc_pkg::*;
#(
    parameter int RESTART_CYCLES = RESTART_CYC,
    parameter int SEQ_STEP_CYCLES = SEQ_STEP_CYC
)(
    input wire logic CORE_CLK,
    input wire logic RESETN,
    input wire logic BUCK1_MODE_PIN,
    input wire logic BUCK4_LDO_MODE,
    input wire logic BYPASS_CMP_RISE,
    input wire logic BYPASS_CMP_FALL,
    input wire logic SUPPLY_OVER_3V8,
    input wire logic LDO1_ILIM_HIT,
    input wire logic LDO2_ILIM_HIT,
    input wire logic LDO1_UNDERVOLT,
    input wire logic LDO2_UNDERVOLT,
    input wire logic [NUM_RAILS-1:0] RAIL_DISABLE,
    input wire rfmc_mask_s MASK_CLEAR,
    input wire rfmc_mask_s MASK_SET,
    input wire logic FAULT_SHUTDOWN_DISABLE,
    input wire rfmc_ldo_cfg_s LDO1_CFG,
    input wire rfmc_ldo_cfg_s LDO2_CFG,
    input wire logic LDO1_CODE_SEL,
    input wire logic [VCODE_W-1:0] LDO1_VOLTAGE_CODE_A,
    input wire logic [VCODE_W-1:0] LDO1_VOLTAGE_CODE_B,
    input wire logic [VCODE_W-1:0] LDO2_VOLTAGE_CODE,
    input wire logic [VCODE_W-1:0] BUCK4_THIRD_VOLTAGE_SELECT_REG,
    input wire logic ILIM_STATUS_READ,
    output logic [NUM_RAILS-1:0] RAIL_ENABLE,
    output logic [1:0] LDO_DISCHARGE,
    output logic [1:0] LDO_RAMPING,
    output logic [1:0] LDO_CURRENT_LIMIT_HIGH,
    output logic [VCODE_W-1:0] LDO1_VCODE_OUT,
    output logic [VCODE_W-1:0] LDO2_VCODE_OUT,
    output logic [VCODE_W-1:0] BUCK4_LDO_VCODE_OUT,
    output logic BUCK1_BYPASS,
    output logic BUCK4_IS_LDO,
    output logic POWER_OK_FLAG,
    output logic OVERUNDER_FAULT_STATE,
    output logic UNDERVOLTAGE_LOCKOUT_FAULT_STATE,
    output logic [1:0] ILIM_STATUS,
    output rfmc_mask_s FAULT_MASK,
    output logic INTERRUPT_REQUEST_N
);
    initial begin
        if (RESTART_CYCLES < 1 || SEQ_STEP_CYCLES < 1) begin
            $error("Restart and step counts must be at least one cycle.");
        end
    end

    localparam int RW = $clog2(RESTART_CYCLES + 1);
    localparam int SW = $clog2(SEQ_STEP_CYCLES + 1);
    localparam int DW = $clog2(OV_DEGLITCH_CYC + 1);
    localparam int IW = $clog2(NUM_RAILS + 1);

    rfmc_state_e state_reg;
    logic [RW-1:0] restart_cnt_reg;
    logic [SW-1:0] step_cnt_reg;
    logic [IW-1:0] seq_idx_reg;
    logic [DW-1:0] ov_cnt_reg;
    logic [NUM_RAILS-1:0] rail_en_reg;
    logic [NUM_RAILS-1:0] rail_on_reg;
    logic bypass_reg;
    logic buck4_ldo_reg;
    logic pok_reg;
    logic ovuv_reg;
    logic uvlo_reg;
    logic irq_n_reg;
    logic [1:0] ilim_reg;
    rfmc_mask_s mask_reg;
    logic [1:0] dis_reg;
    logic [1:0] ramp_reg;
    logic [1:0] ilim_scale_reg;
    logic [VCODE_W-1:0] l1_code_reg;
    logic [VCODE_W-1:0] l2_code_reg;
    logic [VCODE_W-1:0] b4_code_reg;
    logic [1:0] ss_ramping;
    logic [1:0] ss_done;

    // Comparator with hysteresis: rise threshold sets, fall threshold clears.
    wire logic pok_next = BYPASS_CMP_RISE ? 1'b1 : (BYPASS_CMP_FALL ? pok_reg : 1'b0);
    wire logic run = (state_reg == ST_SEQ) || (state_reg == ST_ACTIVE);
    wire logic bypass_uv = bypass_reg && run && rail_on_reg[RAIL_B1] && pok_reg && !pok_next
        && !mask_reg.undervoltage;
    // The live comparator is required too, so a count saturated while shutdown was disabled cannot trip late.
    wire logic ov_trip = bypass_reg && run && SUPPLY_OVER_3V8 && (ov_cnt_reg == DW'(OV_DEGLITCH_CYC))
        && !mask_reg.overvoltage && !FAULT_SHUTDOWN_DISABLE;
    wire logic ldo_uv = run && ((LDO1_ILIM_HIT && LDO1_UNDERVOLT && rail_on_reg[RAIL_L1])
        || (LDO2_ILIM_HIT && LDO2_UNDERVOLT && rail_on_reg[RAIL_L2]));
    wire logic fault_go = bypass_uv || ov_trip || ldo_uv;
    wire logic restart_done = (restart_cnt_reg == RW'(RESTART_CYCLES - 1));
    wire logic step_done = (step_cnt_reg == SW'(SEQ_STEP_CYCLES - 1));
    wire logic seq_last = (seq_idx_reg == IW'(NUM_RAILS - 1));
    wire logic [1:0] ilim_hit = {LDO2_ILIM_HIT, LDO1_ILIM_HIT};
    wire logic [1:0] ilim_new = ilim_hit & ~{2{mask_reg.current_limit}};
    wire logic irq_event = ldo_uv || bypass_uv || ov_trip || (|ilim_new);

    // Per-rail enable: set by sequencer, cleared by host disable once active.
    logic [NUM_RAILS-1:0] rail_en_next;
    genvar gi;
    generate
        for (gi = 0; gi < NUM_RAILS; gi++) begin : g_rail
            assign rail_en_next[gi] = (fault_go || state_reg == ST_FAULT || state_reg == ST_OFF) ? 1'b0
                : (state_reg == ST_SEQ && step_done && seq_idx_reg == IW'(gi)) ? 1'b1
                : (state_reg == ST_ACTIVE && RAIL_DISABLE[gi]) ? 1'b0
                : rail_en_reg[gi];
        end
    endgenerate

    rfmc_softstart u_ss_l1 (
        .clk(CORE_CLK),
        .rst_n(RESETN),
        .enable(rail_en_reg[RAIL_L1]),
        .long_sel(LDO1_CFG.softstart_select),
        .ramping(ss_ramping[0]),
        .done(ss_done[0])
    );

    rfmc_softstart u_ss_l2 (
        .clk(CORE_CLK),
        .rst_n(RESETN),
        .enable(rail_en_reg[RAIL_L2]),
        .long_sel(LDO2_CFG.softstart_select),
        .ramping(ss_ramping[1]),
        .done(ss_done[1])
    );

    always_ff @(posedge CORE_CLK) begin
        if (!RESETN) begin
            state_reg <= ST_OFF;
            restart_cnt_reg <= '0;
            step_cnt_reg <= '0;
            seq_idx_reg <= '0;
            rail_en_reg <= '0;
        end else begin
            rail_en_reg <= rail_en_next;
            case (state_reg)
                ST_OFF: begin
                    state_reg <= ST_SEQ;
                    step_cnt_reg <= '0;
                    seq_idx_reg <= '0;
                end
                ST_SEQ: begin
                    if (fault_go) begin
                        state_reg <= ST_FAULT;
                        restart_cnt_reg <= '0;
                    end else if (step_done) begin
                        step_cnt_reg <= '0;
                        seq_idx_reg <= seq_idx_reg + 1'b1;
                        if (seq_last) begin
                            state_reg <= ST_ACTIVE;
                        end
                    end else begin
                        step_cnt_reg <= step_cnt_reg + 1'b1;
                    end
                end
                ST_ACTIVE: begin
                    if (fault_go) begin
                        state_reg <= ST_FAULT;
                        restart_cnt_reg <= '0;
                    end
                end
                ST_FAULT: begin
                    if (restart_done) begin
                        state_reg <= ST_OFF;
                    end else begin
                        restart_cnt_reg <= restart_cnt_reg + 1'b1;
                    end
                end
                default: state_reg <= ST_OFF;
            endcase
        end
    end

    // Straps are caught while rails are down, so a pin change in service is ignored.
    always_ff @(posedge CORE_CLK) begin
        if (!RESETN) begin
            bypass_reg <= 1'b0;
            buck4_ldo_reg <= 1'b0;
        end else if (state_reg == ST_OFF) begin
            bypass_reg <= BUCK1_MODE_PIN;
            buck4_ldo_reg <= BUCK4_LDO_MODE;
        end
    end

    always_ff @(posedge CORE_CLK) begin
        if (!RESETN) begin
            ov_cnt_reg <= '0;
        end else if (!SUPPLY_OVER_3V8 || !bypass_reg) begin
            ov_cnt_reg <= '0;
        end else if (ov_cnt_reg != DW'(OV_DEGLITCH_CYC)) begin
            ov_cnt_reg <= ov_cnt_reg + 1'b1;
        end
    end

    always_ff @(posedge CORE_CLK) begin
        if (!RESETN) begin
            pok_reg <= 1'b0;
            ovuv_reg <= 1'b0;
            uvlo_reg <= 1'b0;
            irq_n_reg <= 1'b1;
            ilim_reg <= '0;
            mask_reg <= '{MASK_RESET, MASK_RESET, MASK_RESET};
        end else begin
            pok_reg <= bypass_reg ? pok_next : rail_on_reg[RAIL_B1];
            mask_reg <= (mask_reg & ~MASK_CLEAR) | MASK_SET;
            if (bypass_uv || ov_trip) begin
                ovuv_reg <= 1'b1;
            end else if (state_reg == ST_FAULT && restart_done) begin
                ovuv_reg <= 1'b0;
            end
            if (ldo_uv) begin
                uvlo_reg <= 1'b1;
            end else if (state_reg == ST_FAULT && restart_done) begin
                uvlo_reg <= 1'b0;
            end
            // A new hit in the read cycle survives the clear.
            ilim_reg <= (ILIM_STATUS_READ ? 2'h0 : ilim_reg) | ilim_new;
            if (irq_event) begin
                irq_n_reg <= 1'b0;
            end else if (ILIM_STATUS_READ && state_reg != ST_FAULT) begin
                irq_n_reg <= 1'b1;
            end
        end
    end

    always_ff @(posedge CORE_CLK) begin
        if (!RESETN) begin
            rail_on_reg <= '0;
            dis_reg <= '0;
            ramp_reg <= '0;
            ilim_scale_reg <= '0;
            l1_code_reg <= VCODE_RESET;
            l2_code_reg <= VCODE_RESET;
            b4_code_reg <= VCODE_RESET;
        end else begin
            rail_on_reg <= rail_en_reg;
            dis_reg <= {!rail_en_reg[RAIL_L2] && LDO2_CFG.discharge_enable,
                !rail_en_reg[RAIL_L1] && LDO1_CFG.discharge_enable};
            ramp_reg <= ss_ramping;
            ilim_scale_reg <= {LDO2_CFG.current_limit_scale, LDO1_CFG.current_limit_scale};
            l1_code_reg <= LDO1_CODE_SEL ? LDO1_VOLTAGE_CODE_B : LDO1_VOLTAGE_CODE_A;
            l2_code_reg <= LDO2_VOLTAGE_CODE;
            b4_code_reg <= BUCK4_THIRD_VOLTAGE_SELECT_REG;
        end
    end

    assign RAIL_ENABLE = rail_on_reg;
    assign LDO_DISCHARGE = dis_reg;
    assign LDO_RAMPING = ramp_reg;
    assign LDO_CURRENT_LIMIT_HIGH = ilim_scale_reg;
    assign LDO1_VCODE_OUT = l1_code_reg;
    assign LDO2_VCODE_OUT = l2_code_reg;
    assign BUCK4_LDO_VCODE_OUT = b4_code_reg;
    assign BUCK1_BYPASS = bypass_reg;
    assign BUCK4_IS_LDO = buck4_ldo_reg;
    assign POWER_OK_FLAG = pok_reg;
    assign OVERUNDER_FAULT_STATE = ovuv_reg;
    assign UNDERVOLTAGE_LOCKOUT_FAULT_STATE = uvlo_reg;
    assign ILIM_STATUS = ilim_reg;
    assign FAULT_MASK = mask_reg;
    assign INTERRUPT_REQUEST_N = irq_n_reg;
endmodule
`default_nettype wire

// [tb/rfmc_properties.sv]
// Concurrent checks on the ports of the fault and mode control block.
`timescale 1ns/1ps
`default_nettype none
module rfmc_properties
    import rfmc_pkg::*;
#(
    parameter int RESTART_CYCLES = RESTART_CYC
)(
    input wire logic CORE_CLK,
    input wire logic RESETN,
    input wire rfmc_ldo_cfg_s LDO1_CFG,
    input wire logic LDO1_CODE_SEL,
    input wire logic [VCODE_W-1:0] LDO1_VOLTAGE_CODE_A,
    input wire logic [VCODE_W-1:0] LDO1_VOLTAGE_CODE_B,
    input wire logic ILIM_STATUS_READ,
    input wire logic [NUM_RAILS-1:0] RAIL_ENABLE,
    input wire logic [1:0] LDO_DISCHARGE,
    input wire logic [1:0] LDO_CURRENT_LIMIT_HIGH,
    input wire logic [VCODE_W-1:0] LDO1_VCODE_OUT,
    input wire logic BUCK4_IS_LDO,
    input wire logic BUCK1_BYPASS,
    input wire logic OVERUNDER_FAULT_STATE,
    input wire logic UNDERVOLTAGE_LOCKOUT_FAULT_STATE,
    input wire logic [1:0] ILIM_STATUS,
    input wire rfmc_mask_s FAULT_MASK,
    input wire logic INTERRUPT_REQUEST_N
);
    default clocking cb @(posedge CORE_CLK); endclocking
    default disable iff (!RESETN);
    wire logic in_fault;
    int fault_cnt;
    assign in_fault = OVERUNDER_FAULT_STATE | UNDERVOLTAGE_LOCKOUT_FAULT_STATE;
    // Counting the fault span lets the long restart wait be bounded without a huge delay.
    always_ff @(posedge CORE_CLK) begin
        if (!RESETN || !in_fault) begin
            fault_cnt <= 0;
        end else begin
            fault_cnt <= fault_cnt + 1;
        end
    end
    sequence s_all_off;
        ##1 RAIL_ENABLE == 6'h00;
    endsequence
    sequence s_ilim_kept;
        ##1 (ILIM_STATUS & $past(ILIM_STATUS)) == $past(ILIM_STATUS);
    endsequence
    a_mask_reset_on: assert property (disable iff (1'b0) !RESETN |=> FAULT_MASK == 3'h7)
        else $error("fault masks not set by reset");
    a_ovuv_rails_off: assert property ($rose(OVERUNDER_FAULT_STATE) |-> s_all_off)
        else $error("rails still on after fault entry");
    a_uvlo_rails_off: assert property ($rose(UNDERVOLTAGE_LOCKOUT_FAULT_STATE) |-> s_all_off)
        else $error("rails still on after lockout entry");
    a_uvlo_irq_low: assert property ($rose(UNDERVOLTAGE_LOCKOUT_FAULT_STATE) |-> !INTERRUPT_REQUEST_N)
        else $error("interrupt not raised on lockout");
    a_fault_holds_off: assert property (in_fault && $past(in_fault) |-> RAIL_ENABLE == 6'h00)
        else $error("rail enabled during fault");
    a_restart_max_wait: assert property (fault_cnt <= RESTART_CYCLES + 4)
        else $error("restart wait too long");
    a_restart_min_wait: assert property ($fell(in_fault) |-> fault_cnt >= RESTART_CYCLES - 4)
        else $error("restart came too early");
    a_ilim_kept_sticky: assert property (!ILIM_STATUS_READ |-> s_ilim_kept)
        else $error("status bit lost without read");
    a_discharge_needs_bit: assert property ((!LDO1_CFG.discharge_enable) [*2] |-> !LDO_DISCHARGE[0])
        else $error("discharge on without its enable");
    a_climit_scale_copy: assert property (1'b1 |=> LDO_CURRENT_LIMIT_HIGH[0] == $past(LDO1_CFG.current_limit_scale))
        else $error("current limit scale not followed");
    a_ldo1_code_pick: assert property (1'b1 |=> LDO1_VCODE_OUT == ($past(LDO1_CODE_SEL) ?
        $past(LDO1_VOLTAGE_CODE_B) : $past(LDO1_VOLTAGE_CODE_A)))
        else $error("wrong voltage code chosen");
    a_strap_frozen_on: assert property (RAIL_ENABLE != 6'h00 |=> $stable(BUCK4_IS_LDO) && $stable(BUCK1_BYPASS))
        else $error("mode changed while output on");
endmodule
bind rfmc_top rfmc_properties #(.RESTART_CYCLES(RESTART_CYCLES)) i_props (
    .CORE_CLK(CORE_CLK), .RESETN(RESETN), .LDO1_CFG(LDO1_CFG), .LDO1_CODE_SEL(LDO1_CODE_SEL),
    .LDO1_VOLTAGE_CODE_A(LDO1_VOLTAGE_CODE_A), .LDO1_VOLTAGE_CODE_B(LDO1_VOLTAGE_CODE_B),
    .ILIM_STATUS_READ(ILIM_STATUS_READ), .RAIL_ENABLE(RAIL_ENABLE), .LDO_DISCHARGE(LDO_DISCHARGE),
    .LDO_CURRENT_LIMIT_HIGH(LDO_CURRENT_LIMIT_HIGH), .LDO1_VCODE_OUT(LDO1_VCODE_OUT),
    .BUCK4_IS_LDO(BUCK4_IS_LDO), .BUCK1_BYPASS(BUCK1_BYPASS), .OVERUNDER_FAULT_STATE(OVERUNDER_FAULT_STATE),
    .UNDERVOLTAGE_LOCKOUT_FAULT_STATE(UNDERVOLTAGE_LOCKOUT_FAULT_STATE), .ILIM_STATUS(ILIM_STATUS),
    .FAULT_MASK(FAULT_MASK), .INTERRUPT_REQUEST_N(INTERRUPT_REQUEST_N)
);
`default_nettype wire

// [tb/rfmc_plant.sv]
// Model of the bypass comparators and the strap pin that face the control block.
`timescale 1ns/1ps
`default_nettype none
module rfmc_plant (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [1:0] level,
    input wire logic mode_req,
    output logic cmp_rise,
    output logic cmp_fall,
    output logic mode_pin
);
    // Level 2 is above both thresholds, 1 lies in the hysteresis band, 0 is below both.
    assign cmp_rise = (level == 2'h2);
    assign cmp_fall = (level != 2'h0);
    // The strap is taken only while reset is held, so it cannot move once startup begins.
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            mode_pin <= mode_req;
        end
    end
endmodule
`default_nettype wire

// [tb/test_rfmc_top.sv]
// Self-checking bench for the regulator fault and mode control block.
`timescale 1ns/1ps
`default_nettype none
module test_rfmc_top
    import rfmc_pkg::*;
;
    localparam int RST_C = 200;
    localparam int STEP_C = 10;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic [1:0] level = 2'h2;
    logic mode_req = 1'b1;
    logic b4_mode = 1'b1;
    logic ov = 1'b0, ilim1 = 1'b0, ilim2 = 1'b0, uv1 = 1'b0, uv2 = 1'b0, fsd = 1'b0, csel = 1'b0, rd = 1'b0;
    logic [5:0] rail_dis = 6'h00, ca = 6'h00, cb = 6'h00, c2 = 6'h00, c4 = 6'h00;
    rfmc_mask_s mclr = 3'h0, mset = 3'h0;
    rfmc_ldo_cfg_s cfg1 = 3'h0, cfg2 = 3'h0;
    wire logic b1_mode, cr, cf, isldo, byp, power_ok_flag, ovuv, uvlo, irq_n;
    wire logic [5:0] rails, vc1, vc2, vc4;
    wire logic [1:0] disch, ramp, clh, ist;
    wire rfmc_mask_s fmask;
    int bad_count = 0, n_checks = 0;
    int sel_q[$];
    logic [31:0] exp_q[$];
    logic [31:0] seed = 32'h0000_001E;
    event probe_ev;
    always #4 clk = ~clk;
    rfmc_plant i_plant (.clk(clk), .rst_n(rst_n), .level(level), .mode_req(mode_req), .cmp_rise(cr),
        .cmp_fall(cf), .mode_pin(b1_mode));
    rfmc_top #(.RESTART_CYCLES(RST_C), .SEQ_STEP_CYCLES(STEP_C)) i_dut (
        .CORE_CLK(clk), .RESETN(rst_n), .BUCK1_MODE_PIN(b1_mode), .BUCK4_LDO_MODE(b4_mode),
        .BYPASS_CMP_RISE(cr), .BYPASS_CMP_FALL(cf), .SUPPLY_OVER_3V8(ov), .LDO1_ILIM_HIT(ilim1),
        .LDO2_ILIM_HIT(ilim2), .LDO1_UNDERVOLT(uv1), .LDO2_UNDERVOLT(uv2), .RAIL_DISABLE(rail_dis),
        .MASK_CLEAR(mclr), .MASK_SET(mset), .FAULT_SHUTDOWN_DISABLE(fsd), .LDO1_CFG(cfg1), .LDO2_CFG(cfg2),
        .LDO1_CODE_SEL(csel), .LDO1_VOLTAGE_CODE_A(ca), .LDO1_VOLTAGE_CODE_B(cb), .LDO2_VOLTAGE_CODE(c2),
        .BUCK4_THIRD_VOLTAGE_SELECT_REG(c4), .ILIM_STATUS_READ(rd), .RAIL_ENABLE(rails),
        .LDO_DISCHARGE(disch), .LDO_RAMPING(ramp), .LDO_CURRENT_LIMIT_HIGH(clh), .LDO1_VCODE_OUT(vc1),
        .LDO2_VCODE_OUT(vc2), .BUCK4_LDO_VCODE_OUT(vc4), .BUCK1_BYPASS(byp), .BUCK4_IS_LDO(isldo),
        .POWER_OK_FLAG(power_ok_flag), .OVERUNDER_FAULT_STATE(ovuv), .UNDERVOLTAGE_LOCKOUT_FAULT_STATE(uvlo),
        .ILIM_STATUS(ist), .FAULT_MASK(fmask), .INTERRUPT_REQUEST_N(irq_n));
    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction
    function automatic logic [31:0] pick(int s);
        case (s)
            0: return 32'(rails);
            1: return 32'(fmask);
            2: return 32'({uvlo, ovuv});
            3: return 32'({ist, irq_n});
            4: return 32'({vc4, vc2, vc1});
            6: return 32'(power_ok_flag);
            7: return 32'(ramp);
            default: return 32'({isldo, byp, clh[0], disch[0]});
        endcase
    endfunction
    task automatic cyc(int n);
        repeat (n) @(posedge clk);
    endtask
    // Probes land 1 ns after the edge so the design's updates have settled.
    task automatic probe(int s, logic [31:0] e);
        #1;
        sel_q.push_back(s);
        exp_q.push_back(e);
        -> probe_ev;
        @(posedge clk);
    endtask
    task automatic check(logic [31:0] seen, logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    always @(probe_ev) begin
        check(pick(sel_q.pop_front()), exp_q.pop_front());
    end
    task automatic wait_up();
        int i;
        i = 0;
        while (rails !== 6'h3F && i < 2000) begin
            @(posedge clk);
            i++;
        end
        probe(0, 32'h0000_003F);
    endtask
    task automatic done(string name);
        $display("test %0s done", name);
    endtask
    task automatic end_of_test();
        $display("checks %0d mismatches %0d", n_checks, bad_count);
        if (bad_count == 0 && n_checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    initial begin
        cyc(20000);
        bad_count++;
        end_of_test();
    end
    initial begin
        logic [31:0] r;
        logic sc;
        cyc(3);
        rst_n <= 1'b1;
        probe(1, 32'h0000_0007);
        wait_up();
        probe(7, 32'h0000_0003);
        probe(5, 32'h0000_000C);
        done("startup");
        for (int k = 0; k < 4; k++) begin
            r = (k == 0) ? 32'hFFFF_FFFF : rnd();
            ca <= r[5:0];
            cb <= r[11:6];
            c2 <= r[17:12];
            c4 <= r[23:18];
            csel <= r[24];
            cfg1.current_limit_scale <= r[25];
            cfg2 <= r[28:26];
            sc = r[25];
            cyc(2);
            probe(4, 32'({r[23:18], r[17:12], r[24] ? r[11:6] : r[5:0]}));
            probe(5, 32'({2'h3, sc, 1'b0}));
        end
        done("codes");
        rail_dis <= 6'h12;
        cfg1.discharge_enable <= 1'b1;
        b4_mode <= 1'b0;
        cyc(4);
        probe(0, 32'h0000_002D);
        probe(5, 32'({2'h3, sc, 1'b1}));
        rail_dis <= 6'h00;
        b4_mode <= 1'b1;
        level <= 2'h1;
        cyc(3);
        probe(6, 32'h0000_0001);
        level <= 2'h0;
        cyc(3);
        probe(6, 32'h0000_0000);
        probe(2, 32'h0000_0000);
        level <= 2'h2;
        mclr.undervoltage <= 1'b1;
        cyc(1);
        mclr <= 3'h0;
        cyc(2);
        probe(1, 32'h0000_0003);
        level <= 2'h0;
        cyc(3);
        probe(2, 32'h0000_0001);
        probe(0, 32'h0000_0000);
        level <= 2'h2;
        mset.undervoltage <= 1'b1;
        cyc(1);
        mset <= 3'h0;
        wait_up();
        probe(1, 32'h0000_0007);
        done("bypass undervoltage");
        mclr.overvoltage <= 1'b1;
        fsd <= 1'b1;
        ov <= 1'b1;
        cyc(1);
        mclr <= 3'h0;
        cyc(1400);
        probe(2, 32'h0000_0000);
        fsd <= 1'b0;
        ov <= 1'b0;
        cyc(1);
        ov <= 1'b1;
        cyc(1000);
        ov <= 1'b0;
        cyc(1);
        probe(2, 32'h0000_0000);
        ov <= 1'b1;
        cyc(1300);
        probe(2, 32'h0000_0001);
        ov <= 1'b0;
        wait_up();
        done("overvoltage");
        // The lockout fault needs the current limit and the undervoltage together.
        ilim1 <= 1'b1;
        uv1 <= 1'b1;
        cyc(2);
        ilim1 <= 1'b0;
        uv1 <= 1'b0;
        cyc(1);
        probe(2, 32'h0000_0002);
        probe(3, 32'h0000_0000);
        probe(0, 32'h0000_0000);
        wait_up();
        done("ldo undervoltage");
        rd <= 1'b1;
        cyc(1);
        rd <= 1'b0;
        ilim2 <= 1'b1;
        cyc(2);
        ilim2 <= 1'b0;
        cyc(2);
        probe(3, 32'h0000_0001);
        mclr.current_limit <= 1'b1;
        cyc(1);
        mclr <= 3'h0;
        ilim2 <= 1'b1;
        cyc(2);
        ilim2 <= 1'b0;
        cyc(10);
        probe(3, 32'h0000_0004);
        rd <= 1'b1;
        cyc(1);
        rd <= 1'b0;
        cyc(2);
        probe(3, 32'h0000_0001);
        done("current limit status");
        end_of_test();
    end
endmodule
`default_nettype wire
